// File: hw/flash_seq.sv
// Command sequencer: wrap setup, page program, sector/block erase.
// Assumes link pins are asynchronous and sampled by ref_clk_in.
`include "flash_seq_map.svh"
module flash_seq #(
  parameter int PROG_CYCLES = `PROG_CYCLES,
  parameter int ERASE_CYCLES = `ERASE_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic chip_select_n_in,
  input wire logic serial_clk_in,
  input wire logic [3:0] quad_io_lines_in,
  input wire logic quad_enable_flag_in,
  input wire logic four_byte_enable_flag_in,
  input wire logic [4:0] block_protect_bits_in,
  input wire logic [31:0] protect_lo_in,
  input wire logic [31:0] protect_hi_in,
  input wire logic quad_peripheral_mode_in,
  output logic write_in_progress_flag_out,
  output logic write_enable_latch_flag_out,
  output logic [2:0] wrap_field_out,
  output logic four_byte_mode_out,
  output logic mem_we_out,
  output logic [31:0] mem_addr_out,
  output logic [7:0] mem_data_out,
  output logic erase_start_out,
  output logic [1:0] erase_size_out,
  output logic [31:0] erase_addr_out
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] cs_sync_reg;
  logic [2:0] sck_sync_reg;
  logic [3:0] io_s1_reg;
  logic [3:0] io_s2_reg;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cs_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h0;
      io_s1_reg <= 4'h0;
      io_s2_reg <= 4'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], chip_select_n_in};
      sck_sync_reg <= {sck_sync_reg[1:0], serial_clk_in};
      io_s1_reg <= quad_io_lines_in;
      io_s2_reg <= io_s1_reg;
    end
  end
  logic cs_low;
  logic cs_rise;
  logic sck_rise;
  assign cs_low = ~cs_sync_reg[1];
  assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2] & cs_low;

  ////////////////////////////////////////////////////////////////////////
  // Frame decoder and status
  flash_seq_pkg::frame_state_type state_reg, state_next;
  flash_seq_pkg::job_type job_reg, job_next;
  logic [7:0] opcode_reg, opcode_next;
  logic [31:0] shift_reg, shift_next;
  logic [5:0] count_reg, count_next;
  logic [31:0] addr_reg, addr_next;
  logic quad_reg, quad_next;
  logic boundary_reg, boundary_next;
  logic got_data_reg, got_data_next;
  logic busy_reg, busy_next;
  logic wr_en_reg, wr_en_next;
  logic fourb_reg, fourb_next;
  logic [2:0] wrap_reg, wrap_next;
  logic [25:0] timer_reg, timer_next;
  logic we_reg, we_next;
  logic [31:0] maddr_reg, maddr_next;
  logic [7:0] mdata_reg, mdata_next;
  logic es_reg, es_next;
  logic [1:0] esz_reg, esz_next;
  logic [31:0] eaddr_reg, eaddr_next;
  logic [7:0] byte_in;
  logic [5:0] addr_bits;
  logic fourb_mode;
  logic prot;

  assign fourb_mode = fourb_reg | four_byte_enable_flag_in;
  assign addr_bits = fourb_mode ? 6'd32 : 6'd24;
  assign prot = (block_protect_bits_in != 5'h00) &&
    (addr_reg >= protect_lo_in) && (addr_reg <= protect_hi_in);

  always_comb begin
    state_next = state_reg;
    job_next = job_reg;
    opcode_next = opcode_reg;
    shift_next = shift_reg;
    count_next = count_reg;
    addr_next = addr_reg;
    quad_next = quad_reg;
    boundary_next = boundary_reg;
    got_data_next = got_data_reg;
    busy_next = busy_reg;
    wr_en_next = wr_en_reg;
    fourb_next = fourb_reg;
    wrap_next = wrap_reg;
    timer_next = timer_reg;
    we_next = 1'b0;
    maddr_next = maddr_reg;
    mdata_next = mdata_reg;
    es_next = 1'b0;
    esz_next = esz_reg;
    eaddr_next = eaddr_reg;
    byte_in = 8'h00;
    if (busy_reg) begin
      if (timer_reg == 26'h0000000) begin
        busy_next = 1'b0;
      end else begin
        timer_next = timer_reg - 26'h0000001;
      end
      if (timer_reg == 26'h0000001) begin
        wr_en_next = 1'b0;
      end
    end
    if (!cs_low) begin
      state_next = flash_seq_pkg::ST_OPCODE;
      count_next = 6'd0;
      quad_next = 1'b0;
    end
    if (cs_rise && !busy_reg) begin
      case (state_reg)
        flash_seq_pkg::ST_DATA: begin
          if (boundary_reg && got_data_reg) begin
            job_next = flash_seq_pkg::JOB_PROG;
            busy_next = 1'b1;
            timer_next = 26'(PROG_CYCLES);
          end
        end
        flash_seq_pkg::ST_ADDR: begin
          if (count_reg == addr_bits && job_reg ==
              flash_seq_pkg::JOB_ERASE && !prot) begin
            es_next = 1'b1;
            eaddr_next = addr_reg;
            busy_next = 1'b1;
            timer_next = 26'(ERASE_CYCLES);
          end
        end
        flash_seq_pkg::ST_OPCODE: begin
          if (count_reg == 6'd8) begin
            if (opcode_reg == `OP_WR_ENABLE) wr_en_next = 1'b1;
            if (opcode_reg == `OP_WRDI) wr_en_next = 1'b0;
            if (opcode_reg == `OP_ADDR4_ON) fourb_next = 1'b1;
            if (opcode_reg == `OP_ADDR4_OFF) fourb_next = 1'b0;
          end
        end
        flash_seq_pkg::ST_WRAP: begin
          if (count_reg == 6'd8) begin
            wrap_next = shift_reg[6:4];
          end
        end
        default: begin
        end
      endcase
    end
    if (sck_rise) begin
      shift_next = quad_reg ? {shift_reg[27:0], io_s2_reg} :
        {shift_reg[30:0], io_s2_reg[0]};
      count_next = count_reg + (quad_reg ? 6'd4 : 6'd1);
      byte_in = shift_next[7:0];
      case (state_reg)
        flash_seq_pkg::ST_OPCODE: begin
          if (count_next == 6'd8) begin
            opcode_next = byte_in;
            count_next = 6'd0;
            state_next = flash_seq_pkg::ST_ADDR;
            job_next = flash_seq_pkg::JOB_NONE;
            if (byte_in == `OP_WRAP) begin
              state_next = flash_seq_pkg::ST_DUMMY;
            end else if (byte_in == `OP_PAGE_PROG) begin
              job_next = flash_seq_pkg::JOB_PROG;
            end else if (byte_in == `OP_QPP && quad_enable_flag_in) begin
              job_next = flash_seq_pkg::JOB_PROG;
            end else if (byte_in == `OP_SECTOR_ERASE) begin
              job_next = flash_seq_pkg::JOB_ERASE;
              esz_next = 2'd0;
            end else if (byte_in == `OP_BE32) begin
              job_next = flash_seq_pkg::JOB_ERASE;
              esz_next = 2'd1;
            end else if (byte_in == `OP_BE64) begin
              job_next = flash_seq_pkg::JOB_ERASE;
              esz_next = 2'd2;
            end else begin
              state_next = flash_seq_pkg::ST_OPCODE;
              count_next = 6'd8;
            end
            if ((job_next != flash_seq_pkg::JOB_NONE && (busy_reg ||
                !wr_en_reg)) || byte_in == `OP_QWRAP ||
                byte_in == `OP_RDPARAM || quad_peripheral_mode_in) begin
              state_next = flash_seq_pkg::ST_IGNORE;
            end
          end else if (count_reg == 6'd8) begin
            state_next = flash_seq_pkg::ST_IGNORE;
          end
        end
        flash_seq_pkg::ST_DUMMY: begin
          if (count_next == `WRAP_DUMMY_BITS) begin
            count_next = 6'd0;
            state_next = flash_seq_pkg::ST_WRAP;
          end
        end
        flash_seq_pkg::ST_WRAP: begin
          if (count_reg == 6'd8) begin
            state_next = flash_seq_pkg::ST_IGNORE;
          end
        end
        flash_seq_pkg::ST_ADDR: begin
          if (count_reg == addr_bits) begin
            state_next = flash_seq_pkg::ST_IGNORE;
          end else if (count_next == addr_bits) begin
            addr_next = fourb_mode ? shift_next : {8'h00, shift_next[23:0]};
            if (job_reg == flash_seq_pkg::JOB_PROG) begin
              state_next = flash_seq_pkg::ST_DATA;
              count_next = 6'd0;
              got_data_next = 1'b0;
              boundary_next = 1'b1;
              quad_next = (opcode_reg == `OP_QPP);
            end
          end
        end
        flash_seq_pkg::ST_DATA: begin
          boundary_next = 1'b0;
          if (count_next == 6'd8) begin
            count_next = 6'd0;
            boundary_next = 1'b1;
            got_data_next = 1'b1;
            we_next = 1'b1;
            maddr_next = addr_reg;
            mdata_next = byte_in;
            addr_next = {addr_reg[31:8], addr_reg[7:0] + 8'h01};
          end
        end
        default: begin
          state_next = flash_seq_pkg::ST_IGNORE;
        end
      endcase
    end
    if (cs_low && state_reg == flash_seq_pkg::ST_DATA && prot) begin
      state_next = flash_seq_pkg::ST_IGNORE;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= flash_seq_pkg::ST_OPCODE;
      job_reg <= flash_seq_pkg::JOB_NONE;
      opcode_reg <= 8'h00;
      shift_reg <= 32'h00000000;
      count_reg <= 6'd0;
      addr_reg <= 32'h00000000;
      quad_reg <= 1'b0;
      boundary_reg <= 1'b0;
      got_data_reg <= 1'b0;
      busy_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      fourb_reg <= 1'b0;
      wrap_reg <= `WRAP_FIELD_RESET;
      timer_reg <= 26'h0000000;
      we_reg <= 1'b0;
      maddr_reg <= 32'h00000000;
      mdata_reg <= 8'h00;
      es_reg <= 1'b0;
      esz_reg <= 2'd0;
      eaddr_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      job_reg <= job_next;
      opcode_reg <= opcode_next;
      shift_reg <= shift_next;
      count_reg <= count_next;
      addr_reg <= addr_next;
      quad_reg <= quad_next;
      boundary_reg <= boundary_next;
      got_data_reg <= got_data_next;
      busy_reg <= busy_next;
      wr_en_reg <= wr_en_next;
      fourb_reg <= fourb_next;
      wrap_reg <= wrap_next;
      timer_reg <= timer_next;
      we_reg <= we_next;
      maddr_reg <= maddr_next;
      mdata_reg <= mdata_next;
      es_reg <= es_next;
      esz_reg <= esz_next;
      eaddr_reg <= eaddr_next;
    end
  end

  assign write_in_progress_flag_out = busy_reg;
  assign write_enable_latch_flag_out = wr_en_reg;
  assign wrap_field_out = wrap_reg;
  assign four_byte_mode_out = fourb_reg;
  assign mem_we_out = we_reg;
  assign mem_addr_out = maddr_reg;
  assign mem_data_out = mdata_reg;
  assign erase_start_out = es_reg;
  assign erase_size_out = esz_reg;
  assign erase_addr_out = eaddr_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb_core @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_erase_sets_busy;
    es_reg |-> busy_reg;
  endproperty
  a_erase_sets_busy: assert property (p_erase_sets_busy)
    else $error("erase started without progress flag");
  property p_busy_clears_wr_en;
    $fell(busy_reg) |-> !wr_en_reg;
  endproperty
  a_busy_clears_wr_en: assert property (p_busy_clears_wr_en)
    else $error("write enable latch still set after cycle");
  property p_page_wrap;
    we_next |=> addr_reg[31:8] == $past(addr_reg[31:8]);
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("program address left its page");
  property p_no_start_without_wr_en;
    (es_next || (cs_rise && busy_next && !busy_reg)) |-> wr_en_reg;
  endproperty
  a_no_start_without_wr_en: assert property (p_no_start_without_wr_en)
    else $error("cycle started without write enable");
  property p_prog_start;
    (cs_rise && !busy_reg && state_reg == flash_seq_pkg::ST_DATA &&
      boundary_reg && got_data_reg) |=> busy_reg;
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("program cycle not started on select rise");
  property p_write_in_data;
    we_reg |-> $past(state_reg) == flash_seq_pkg::ST_DATA;
  endproperty
  a_write_in_data: assert property (p_write_in_data)
    else $error("memory write outside data phase");
endmodule // flash_seq

// File: hw/flash_seq_map.svh
// Constants for the serial flash program/erase/wrap sequencer.
// Assumes a 200 MHz core clock sampling the serial link pins.
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define OP_WRAP 8'h77
`define OP_PAGE_PROG 8'h02
`define OP_QPP 8'h32
`define OP_SECTOR_ERASE 8'h20
`define OP_BE32 8'h52
`define OP_BE64 8'hD8
`define OP_WR_ENABLE 8'h06
`define OP_WRDI 8'h04
`define OP_ADDR4_ON 8'hB7
`define OP_ADDR4_OFF 8'hE9
`define OP_QWRAP 8'h0C
`define OP_RDPARAM 8'hC0
`define WRAP_DUMMY_BITS 6'd24
`define WRAP_FIELD_RESET 3'h1
`define PAGE_BYTES 9'h100
`define CLK_NS 5
`define PROG_TIME_NS 400000
`define ERASE_TIME_NS 45000000
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_NS)
`define ERASE_CYCLES (`ERASE_TIME_NS / `CLK_NS)
`endif

// File: hw/flash_seq_pkg.sv
// Types for the serial flash sequencer.
// Assumes flash_seq_map.svh supplies the numeric constants.
package flash_seq_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_WRAP = 3'b011,
    ST_DATA = 3'b100,
    ST_IGNORE = 3'b101
  } frame_state_type;
  typedef enum logic [1:0] {
    JOB_NONE = 2'b00,
    JOB_PROG = 2'b01,
    JOB_ERASE = 2'b10
  } job_type;
endpackage

// File: tb/flash_host.sv
// Host flash controller model driving chip select, link clock and data.
// Assumes the bench calls frame() only while the link is idle.
module flash_host (
  output logic chip_select_n_out,
  output logic serial_clk_out,
  output logic [3:0] quad_io_lines_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chip_select_n_out = 1'b1;
    serial_clk_out = 1'b0;
    quad_io_lines_out = 4'hA;
  end
  ////////////////////////////////////////////////////////////////////////
  // One link clock period, data set while the clock is low
  task automatic bit_out(input logic [3:0] v);
    quad_io_lines_out = v;
    #32;
    serial_clk_out = 1'b1;
    #32;
    serial_clk_out = 1'b0;
  endtask
  // Bytes MSB first; from byte q on as nibbles on four lines
  task automatic frame(input logic [7:0] b [8], input int n, input int q,
                       input int extra);
    chip_select_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i >= q) begin
        bit_out(b[i][7:4]);
        bit_out(b[i][3:0]);
      end else begin
        for (int k = 7; k >= 0; k--) bit_out({~quad_io_lines_out[3:1],
                                              b[i][k]});
      end
    end
    for (int k = 0; k < extra; k++) bit_out(~quad_io_lines_out);
    #32;
    chip_select_n_out = 1'b1;
    quad_io_lines_out = ~quad_io_lines_out;
    #200;
  endtask
endmodule // flash_host

// File: tb/testbench.sv
// Self-checking bench for the flash program/erase/wrap sequencer.
// Assumes flash_seq and flash_host are compiled beforehand.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 20;
  localparam int ERASE = 50;
  logic ref_clk_in, reset_n_in, cs_n, sclk, quad_en, fb, qpm;
  logic busy, wr_en, fbm, mwe, es;
  logic [3:0] io;
  logic [4:0] bp;
  logic [2:0] wf;
  logic [1:0] esz;
  logic [7:0] md;
  logic [31:0] plo, phi, ma, ea, a;
  logic [31:0] msk [3] = '{32'hFFFFF000, 32'hFFFF8000, 32'hFFFF0000};
  logic [7:0] ops [3] = '{8'h20, 8'h52, 8'hD8};
  logic [7:0] b [8];
  logic [39:0] wq [$];
  int n_mismatch, compares, nbusy, busy_len, n_er, seed;
  flash_seq #(.PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE)) i_flash_seq (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .chip_select_n_in(cs_n), .serial_clk_in(sclk),
    .quad_io_lines_in(io), .quad_enable_flag_in(quad_en),
    .four_byte_enable_flag_in(fb), .block_protect_bits_in(bp),
    .protect_lo_in(plo), .protect_hi_in(phi),
    .quad_peripheral_mode_in(qpm), .write_in_progress_flag_out(busy),
    .write_enable_latch_flag_out(wr_en), .wrap_field_out(wf),
    .four_byte_mode_out(fbm), .mem_we_out(mwe), .mem_addr_out(ma),
    .mem_data_out(md), .erase_start_out(es), .erase_size_out(esz),
    .erase_addr_out(ea));
  flash_host i_flash_host (.chip_select_n_out(cs_n),
    .serial_clk_out(sclk), .quad_io_lines_out(io));
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////
  // Output monitor
  always @(negedge ref_clk_in) begin
    if (mwe === 1'b1) wq.push_back({ma, md});
    if (es === 1'b1) n_er++;
    if (busy === 1'b1) nbusy++;
    else if (nbusy != 0) begin
      busy_len = nbusy;
      nbusy = 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Frame, then poll the progress flag until clear
  task automatic go(input int n, input int q, input int extra);
    int i;
    wq.delete();
    n_er = 0;
    busy_len = 0;
    i_flash_host.frame(b, n, q, extra);
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge ref_clk_in);
    if (i == 400) begin
      n_mismatch++;
      end_sim();
    end
    repeat (3) @(negedge ref_clk_in);
  endtask
  task automatic load(input logic [7:0] op, input logic [31:0] ad,
                      input int na);
    b[0] = op;
    for (int i = 0; i < na; i++) b[1 + i] = ad[8 * (na - 1 - i) +: 8];
  endtask
  task automatic set_wr_en();
    b[0] = 8'h06;
    go(1, 8, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hB2286E75;
    {reset_n_in, quad_en, fb, qpm} = '0;
    bp = 5'h04;
    plo = 32'h00FF0000;
    phi = 32'h00FFFFFF;
    repeat (6) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    chk({busy, wr_en, wf}, 5'h01);
    for (int i = 0; i < 5; i++) begin
      load(8'h77, $random(seed), 3);
      b[4] = {1'b0, i[1:0], i == 4, 4'($random(seed))};
      go(5, 8, 0);
      chk(wf, b[4][6:4]);
    end
    a = $random(seed) & 32'h007FFF00 | 32'hFF;
    load(8'h02, a, 3);
    b[4] = $random(seed);
    b[5] = $random(seed);
    go(6, 8, 0);
    chk(wq.size() + busy_len, 0);
    set_wr_en();
    chk(wr_en, 1'b1);
    load(8'h02, a, 3);
    go(6, 8, 0);
    chk(wq.size(), 2);
    chk(wq[0], {a, b[4]});
    chk(wq[1], {a & 32'hFFFFFF00, b[5]});
    chk(busy_len, PROG + 1);
    chk(wr_en, 1'b0);
    set_wr_en();
    b[0] = 8'h32;
    go(5, 4, 0);
    chk(wq.size() + busy_len, 0);
    @(negedge ref_clk_in);
    quad_en = 1'b1;
    go(5, 4, 0);
    chk(wq.size(), 1);
    chk(wq[0], {a, b[4]});
    set_wr_en();
    load(8'h02, 32'hFF0010, 3);
    go(5, 8, 0);
    chk(wq.size() + busy_len, 0);
    load(8'h02, a, 3);
    go(5, 8, 3);
    chk(busy_len, 0);
    b[0] = 8'hB7;
    go(1, 8, 0);
    chk(fbm, 1'b1);
    b[0] = 8'hE9;
    go(1, 8, 0);
    chk(fbm, 1'b0);
    for (int k = 0; k < 3; k++) begin
      @(negedge ref_clk_in);
      fb = (k == 2);
      set_wr_en();
      a = $random(seed) & (k == 2 ? 32'h7F7FFFFF : 32'h007FFFFF);
      load(ops[k], a, 3 + fb);
      go(4 + fb, 8, 0);
      chk(n_er, 1);
      chk(esz, k);
      chk(ea & msk[k], a & msk[k]);
      chk(busy_len, ERASE + 1);
      chk(wr_en, 1'b0);
    end
    @(negedge ref_clk_in);
    fb = 1'b0;
    qpm = 1'b1;
    set_wr_en();
    chk(wr_en, 1'b0);
    @(negedge ref_clk_in);
    qpm = 1'b0;
    set_wr_en();
    load(8'h20, 32'h001000, 3);
    go(4, 8, 2);
    chk(n_er + busy_len, 0);
    load(8'h20, 32'hFF8000, 3);
    go(4, 8, 0);
    chk(n_er + busy_len, 0);
    end_sim();
  end
endmodule // testbench
